// [shared/pvs_pkg.sv]
// Package for the byte lane steering block of the bus bridge.
// Assumes a single 100 MHz clock domain and synchronous active-low resets.
package pvs_pkg;

    localparam int PVS_DATA_W = 32;
    localparam int PVS_ADDR_W = 31;
    localparam int PVS_OPT_W = 36;
    // Tri-state lead before a direction control turns inward, in cycles
    localparam int PVS_TURN_LEAD_CYC = 1;
    // Fast clock periods that transceiver enable stays negated after system reset
    localparam int PVS_SYSRST_HOLD_CYC = 8;
    localparam logic [2:0] PVS_DIR_RESET = 3'h0;
    localparam logic [PVS_OPT_W-1:0] PVS_OPT_RESET = 36'h000000000;

    typedef enum logic [1:0] {
        PVS_IDLE,
        PVS_DRIVE,
        PVS_RELEASE
    } pvs_dir_e;

    // Steering result for one access
    typedef struct packed {
        logic [3:0] sel0;
        logic [3:0] sel1;
        logic [3:0] sel2;
        logic [3:0] sel3;
        logic ds1;
        logic ds0;
        logic a1;
        logic lword;
        logic legal;
    } pvs_map_s;

endpackage : pvs_pkg

// [rtl/pvs_opt_store.sv]
// Small register store holding the captured power-up option word.
// Assumes the caller pulses the capture strobe once per power-up release.
`timescale 1ns/100ps
module pvs_opt_store
    import pvs_pkg::*;
#(
    parameter int WIDTH = PVS_OPT_W
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic capture,
    input wire logic [WIDTH-1:0] wdata,
    output logic [WIDTH-1:0] rdata
);

    typedef struct packed {
        logic [WIDTH-1:0] word;
    } pvs_store_s;

    pvs_store_s state;
    pvs_store_s next_state;

    always_comb begin
        next_state = state;
        if (capture) begin
            next_state.word = wdata;
        end
    end

    // Power reset does not clear the store: the value lives past the latch edge
    always_ff @(posedge sys_clk) begin
        state <= next_state;
    end

    assign rdata = state.word;

endmodule : pvs_opt_store

// [rtl/pvs_lane_steer.sv]
// Byte lane steering, 64-bit unpack and transceiver direction control.
// Assumes the PCI side presents one access per cycle with its byte enables and low address bits.
`timescale 1ns/100ps
//////////////////////////////////////////////////////////////////////////////////////////////////////////////////////
// Function
// - Always translate PCI to VME data address-invariantly.
// - Single byte, address 00 and 01: lanes, strobes, A1, LWORD per table.
// - Single byte, address 10 and 11: lanes, strobes, A1, LWORD per table.
// - Two-byte accesses swap lanes, both strobes low, A1/LWORD per table.
// - Three-byte accesses reverse lanes, A1 and LWORD low.
// - Full word access reverses all lanes, strobes, A1, LWORD low.
// - 64-bit unpack yields two words, all enables, address bit 2 picks half.
// - First unpack word: low PCI bytes from VME address A31-A16.
// - First unpack word: upper PCI bytes from A15-A8, A7-A1 plus LWORD.
// - Direction controls high while driving the VME lines.
// - Direction controls low while the VME bus drives inward.
// - Address strobe direction has its own separate control.
// - Tri-state outputs one clock before the grouped directions turn inward; the address strobe direction turns inward with no lead.
// - Option pins default low, the 64-bit request pin defaults high.
// - No VME drive in reset; enable negated during and after system reset.
// - Capture option values from address and data pins at power reset release.
module pvs_lane_steer
    import pvs_pkg::*;
#(
    parameter int SYSRST_HOLD = PVS_SYSRST_HOLD_CYC
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic power_on_reset_n,
    input wire logic vme_sysrst_n,
    input wire logic acc_valid,
    input wire logic acc_write,
    input wire logic acc_unpack,
    input wire logic [3:0] acc_be_n,
    input wire logic [2:0] acc_addr,
    input wire logic [PVS_DATA_W-1:0] pci_wdata,
    output logic [PVS_DATA_W-1:0] pci_rdata,
    output logic [3:0] pci_rbe_n,
    output logic acc_error,
    input wire logic vme_out_req,
    input wire logic as_out_req,
    input wire logic [PVS_ADDR_W-1:0] vme_side_address_pins_in,
    input wire logic [PVS_DATA_W-1:0] vme_side_data_pins_in,
    input wire logic vme_lword_in,
    input wire logic req64_pin_in,
    output logic [PVS_DATA_W-1:0] vme_side_data_pins_out,
    output logic vme_side_pins_oe_n,
    output logic vme_ds1,
    output logic vme_ds0,
    output logic vme_a1,
    output logic vme_lword,
    output logic addr_xcvr_dir,
    output logic addr_modifier_xcvr_dir,
    output logic addr_strobe_xcvr_dir,
    output logic data_xcvr_dir,
    output logic data_strobe_xcvr_dir,
    output logic slave_group_xcvr_dir,
    output logic syscon_group_xcvr_dir,
    output logic xcvr_output_enable_n,
    output logic [PVS_OPT_W-1:0] power_up_options,
    output logic pci_bus_64
);

    initial begin
        if (SYSRST_HOLD < 1 || SYSRST_HOLD > 255) begin
            $error("SYSRST_HOLD out of range");
        end
    end

    //////////////////////////////////////////////////////////////////////////////////////////////////////////////////
    // Lane map decode; sel[k] gives the PCI byte that feeds VME byte k (one-hot)
    function automatic pvs_map_s lane_map(input logic [3:0] be_n, input logic [1:0] a);
        pvs_map_s m;
        m = '{sel0: 4'h0, sel1: 4'h0, sel2: 4'h0, sel3: 4'h0, ds1: 1'b1, ds0: 1'b1, a1: 1'b0, lword: 1'b1,
              legal: 1'b1};
        case ({be_n, a})
            6'b1110_00: begin m.sel1 = 4'h1; m.ds1 = 1'b0; end
            6'b1101_01: begin m.sel0 = 4'h2; m.ds0 = 1'b0; end
            6'b1011_10: begin m.sel1 = 4'h4; m.ds1 = 1'b0; m.a1 = 1'b1; end
            6'b0111_11: begin m.sel0 = 4'h8; m.ds0 = 1'b0; m.a1 = 1'b1; end
            6'b1100_00: begin
                m.sel1 = 4'h1; m.sel0 = 4'h2; m.ds1 = 1'b0; m.ds0 = 1'b0;
            end
            6'b1001_01: begin
                m.sel2 = 4'h2; m.sel1 = 4'h4; m.ds1 = 1'b0; m.ds0 = 1'b0; m.a1 = 1'b1; m.lword = 1'b0;
            end
            6'b0011_10: begin
                m.sel1 = 4'h4; m.sel0 = 4'h8; m.ds1 = 1'b0; m.ds0 = 1'b0; m.a1 = 1'b1;
            end
            6'b1000_00: begin
                m.sel3 = 4'h1; m.sel2 = 4'h2; m.sel1 = 4'h4; m.ds0 = 1'b0; m.lword = 1'b0;
            end
            6'b0001_01: begin
                m.sel2 = 4'h2; m.sel1 = 4'h4; m.sel0 = 4'h8; m.ds1 = 1'b0; m.lword = 1'b0;
            end
            6'b0000_00: begin
                m.sel3 = 4'h1; m.sel2 = 4'h2; m.sel1 = 4'h4; m.sel0 = 4'h8;
                m.ds1 = 1'b0; m.ds0 = 1'b0; m.lword = 1'b0;
            end
            default: begin
                m.legal = 1'b0;
            end
        endcase
        return m;
    endfunction : lane_map

    // Pick one byte from a word by one-hot select
    function automatic logic [7:0] pick(input logic [3:0] sel, input logic [31:0] w);
        logic [7:0] r;
        r = 8'h00;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r = w[i*8 +: 8];
            end
        end
        return r;
    endfunction : pick

    // Read direction mirrors the write map, so a byte comes back on the lane it went out on
    function automatic logic [31:0] gather(input pvs_map_s m, input logic [31:0] w);
        logic [31:0] r;
        r = 32'h00000000;
        for (int i = 0; i < 4; i++) begin
            if (m.sel0[i]) r[i*8 +: 8] = w[7:0];
            if (m.sel1[i]) r[i*8 +: 8] = w[15:8];
            if (m.sel2[i]) r[i*8 +: 8] = w[23:16];
            if (m.sel3[i]) r[i*8 +: 8] = w[31:24];
        end
        return r;
    endfunction : gather

    //////////////////////////////////////////////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        pvs_dir_e dir_st;
        logic drive_oe;
        logic as_dir;
        logic [7:0] hold_cnt;
        logic xcvr_en;
        logic por_prev;
        logic [PVS_DATA_W-1:0] vdata;
        logic [PVS_DATA_W-1:0] rdata;
        logic [3:0] rbe_n;
        logic err;
        logic ds1;
        logic ds0;
        logic a1;
        logic lword;
        logic pci64;
    } pvs_state_s;

    pvs_state_s state;
    pvs_state_s next_state;
    pvs_map_s amap;
    logic any_reset;
    logic opt_capture;
    logic [PVS_OPT_W-1:0] opt_word;
    logic [PVS_DATA_W-1:0] vme_swap;

    assign amap = lane_map(acc_be_n, acc_addr[1:0]);
    assign any_reset = !rst_n || !power_on_reset_n || !vme_sysrst_n;
    // Option pins sampled on the release edge of the power reset
    assign opt_capture = power_on_reset_n && !state.por_prev;
    assign opt_word = {vme_side_data_pins_in[31:27], vme_side_address_pins_in};
    // Full reversal of the VME word, used only for the second unpack word
    assign vme_swap = {vme_side_data_pins_in[7:0], vme_side_data_pins_in[15:8],
                       vme_side_data_pins_in[23:16], vme_side_data_pins_in[31:24]};

    always_comb begin
        next_state = state;
        next_state.por_prev = power_on_reset_n;
        next_state.err = 1'b0;
        // Direction sequencer: outputs float one cycle before the turn inward
        case (state.dir_st)
            PVS_IDLE: begin
                if (vme_out_req) begin
                    next_state.dir_st = PVS_DRIVE;
                    next_state.drive_oe = 1'b1;
                end
            end
            PVS_DRIVE: begin
                if (!vme_out_req) begin
                    next_state.dir_st = PVS_RELEASE;
                    next_state.drive_oe = 1'b0;
                end
            end
            PVS_RELEASE: begin
                next_state.dir_st = PVS_IDLE;
            end
            default: begin
                next_state.dir_st = PVS_IDLE;
                next_state.drive_oe = 1'b0;
            end
        endcase
        // Early bus release needs the strobe direction on its own path
        next_state.as_dir = as_out_req;
        if (acc_valid) begin
            if (acc_unpack) begin
                next_state.rbe_n = 4'h0;
                if (!acc_addr[2]) begin
                    next_state.rdata = {vme_side_address_pins_in[6:0], vme_lword_in,
                                        vme_side_address_pins_in[14:7],
                                        vme_side_address_pins_in[22:15],
                                        vme_side_address_pins_in[30:23]};
                end else begin
                    next_state.rdata = vme_swap;
                end
            end else if (!amap.legal) begin
                next_state.err = 1'b1;
            end else begin
                next_state.ds1 = amap.ds1;
                next_state.ds0 = amap.ds0;
                next_state.a1 = amap.a1;
                next_state.lword = amap.lword;
                if (acc_write) begin
                    next_state.vdata = {pick(amap.sel3, pci_wdata), pick(amap.sel2, pci_wdata),
                                        pick(amap.sel1, pci_wdata), pick(amap.sel0, pci_wdata)};
                end else begin
                    next_state.rdata = gather(amap, vme_side_data_pins_in);
                    next_state.rbe_n = acc_be_n;
                end
            end
        end
        // Transceiver enable stays negated during and after a system reset
        if (!vme_sysrst_n) begin
            next_state.hold_cnt = 8'(SYSRST_HOLD);
            next_state.xcvr_en = 1'b0;
        end else if (state.hold_cnt != 8'h00) begin
            next_state.hold_cnt = state.hold_cnt - 8'h01;
        end else begin
            next_state.xcvr_en = 1'b1;
        end
        if (any_reset) begin
            next_state.dir_st = PVS_IDLE;
            next_state.drive_oe = 1'b0;
            next_state.as_dir = 1'b0;
        end
        // Undriven request pin reads high through its pull-up, meaning 32-bit
        if (opt_capture) begin
            next_state.pci64 = !req64_pin_in;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state <= '{dir_st: PVS_IDLE, drive_oe: 1'b0, as_dir: 1'b0, hold_cnt: 8'h00, xcvr_en: 1'b0,
                       por_prev: 1'b1, vdata: 32'h00000000, rdata: 32'h00000000, rbe_n: 4'hf, err: 1'b0,
                       ds1: 1'b1, ds0: 1'b1, a1: 1'b0, lword: 1'b1, pci64: 1'b0};
        end else begin
            state <= next_state;
        end
    end

    //////////////////////////////////////////////////////////////////////////////////////////////////////////////////
    pvs_opt_store #(
        .WIDTH(PVS_OPT_W)
    ) u_opt (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .capture(opt_capture),
        .wdata(opt_word),
        .rdata(power_up_options)
    );

    // Groups stay outward through the release cycle, so the pins float before the turn
    assign addr_xcvr_dir = (state.dir_st == PVS_DRIVE || state.dir_st == PVS_RELEASE) && !any_reset;
    assign addr_modifier_xcvr_dir = addr_xcvr_dir;
    assign data_xcvr_dir = addr_xcvr_dir;
    assign data_strobe_xcvr_dir = addr_xcvr_dir;
    assign slave_group_xcvr_dir = addr_xcvr_dir;
    assign syscon_group_xcvr_dir = addr_xcvr_dir;
    assign addr_strobe_xcvr_dir = state.as_dir && !any_reset;
    assign vme_side_pins_oe_n = !(state.drive_oe && !any_reset);
    assign xcvr_output_enable_n = !state.xcvr_en || !vme_sysrst_n;
    assign vme_side_data_pins_out = state.vdata;
    assign vme_ds1 = state.ds1;
    assign vme_ds0 = state.ds0;
    assign vme_a1 = state.a1;
    assign vme_lword = state.lword;
    assign pci_rdata = state.rdata;
    assign pci_rbe_n = state.rbe_n;
    assign acc_error = state.err;
    assign pci_bus_64 = state.pci64;

endmodule : pvs_lane_steer

// [verif/pvs_lane_steer_properties.sv]
// Concurrent checks on the lane steering block, watching its ports only.
// Assumes a bind from the bench that hands on the hold parameter.
`timescale 1ns/100ps
module pvs_lane_steer_props
    import pvs_pkg::*;
#(
    parameter int SYSRST_HOLD = PVS_SYSRST_HOLD_CYC
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic power_on_reset_n,
    input wire logic vme_sysrst_n,
    input wire logic acc_valid,
    input wire logic acc_write,
    input wire logic acc_unpack,
    input wire logic [3:0] acc_be_n,
    input wire logic [2:0] acc_addr,
    input wire logic [PVS_DATA_W-1:0] pci_wdata,
    input wire logic [PVS_DATA_W-1:0] pci_rdata,
    input wire logic [3:0] pci_rbe_n,
    input wire logic acc_error,
    input wire logic vme_out_req,
    input wire logic as_out_req,
    input wire logic [PVS_ADDR_W-1:0] vme_side_address_pins_in,
    input wire logic [PVS_DATA_W-1:0] vme_side_data_pins_in,
    input wire logic vme_lword_in,
    input wire logic [PVS_DATA_W-1:0] vme_side_data_pins_out,
    input wire logic vme_side_pins_oe_n,
    input wire logic vme_ds1,
    input wire logic vme_ds0,
    input wire logic vme_a1,
    input wire logic vme_lword,
    input wire logic addr_xcvr_dir,
    input wire logic addr_strobe_xcvr_dir,
    input wire logic data_xcvr_dir,
    input wire logic syscon_group_xcvr_dir,
    input wire logic xcvr_output_enable_n
);
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);
    logic [7:0] sr_cnt;
    logic [PVS_ADDR_W-1:0] p_va;
    logic [PVS_DATA_W-1:0] p_vd;
    logic [PVS_DATA_W-1:0] p_wd;
    logic p_lw;
    wire live = power_on_reset_n && vme_sysrst_n;
    wire [2:0] dirs = {addr_xcvr_dir, data_xcvr_dir, syscon_group_xcvr_dir};
    //////////////////////////////////////////////////////////////
    // Counter instead of a long repetition, so the hold may grow
    always_ff @(posedge sys_clk) begin
        if (!vme_sysrst_n) begin
            sr_cnt <= 8'h00;
        end else if (!rst_n) begin
            sr_cnt <= 8'hff;
        end else if (sr_cnt != 8'hff) begin
            sr_cnt <= sr_cnt + 8'h01;
        end
        p_va <= vme_side_address_pins_in;
        p_vd <= vme_side_data_pins_in;
        p_wd <= pci_wdata;
        p_lw <= vme_lword_in;
    end
    //////////////////////////////////////////////////////////////
    AST_RST_DIRS_LOW: assert property (
        !live |-> dirs == 3'h0 && !addr_strobe_xcvr_dir && vme_side_pins_oe_n)
        else $error("Direction outward during reset");
    AST_DRIVE_OUT: assert property (
        live && $rose(vme_out_req) |=> dirs == 3'h7 && !vme_side_pins_oe_n)
        else $error("Direction not outward while driving");
    AST_TRISTATE_LEAD: assert property (
        live && $fell(data_xcvr_dir) |-> $past(vme_side_pins_oe_n))
        else $error("Direction turned before tri-state");
    AST_TURN_IN: assert property (
        live && $fell(vme_out_req) |-> ##[1:3] dirs == 3'h0 && vme_side_pins_oe_n)
        else $error("Direction not inward after release");
    AST_AS_SEPARATE: assert property (
        (live && as_out_req && !vme_out_req)[*3] |-> addr_strobe_xcvr_dir && !data_xcvr_dir)
        else $error("Strobe direction not independent");
    AST_FULL_WORD: assert property (acc_valid && acc_write && !acc_unpack && acc_be_n == 4'h0 && acc_addr[1:0] == 2'h0
        |=> vme_side_data_pins_out == {p_wd[7:0], p_wd[15:8], p_wd[23:16], p_wd[31:24]}
        && {vme_ds1, vme_ds0, vme_a1, vme_lword} == 4'h0)
        else $error("Full word write not reversed");
    AST_ILLEGAL: assert property (acc_valid && !acc_unpack && acc_be_n == 4'he && acc_addr[1:0] == 2'h1
        |=> acc_error ##1 !acc_error)
        else $error("Bad combination not flagged once");
    AST_UNPACK_HI: assert property (acc_valid && acc_unpack && acc_addr == 3'h0
        |=> pci_rdata == {p_va[6:0], p_lw, p_va[14:7], p_va[22:15], p_va[30:23]} && pci_rbe_n == 4'h0)
        else $error("First unpack word wrong");
    AST_UNPACK_LO: assert property (acc_valid && acc_unpack && acc_addr == 3'h4
        |=> pci_rdata == {p_vd[7:0], p_vd[15:8], p_vd[23:16], p_vd[31:24]} && pci_rbe_n == 4'h0)
        else $error("Second unpack word wrong");
    AST_SYSRST_HOLD: assert property (vme_sysrst_n && sr_cnt < SYSRST_HOLD |-> xcvr_output_enable_n)
        else $error("Transceivers enabled too soon");
    cover property (acc_valid && acc_write);
    cover property (acc_valid && acc_unpack);
    cover property ($fell(data_xcvr_dir));
endmodule : pvs_lane_steer_props

// [verif/pvs_vme_partner.sv]
// Far-side model: backplane seen through the transceivers, plus board straps.
// Assumes the bench supplies the backplane word and the strap values.
`timescale 1ns/100ps
module pvs_vme_partner
    import pvs_pkg::*;
(
    input wire logic xcvr_output_enable_n,
    input wire logic data_xcvr_dir,
    input wire logic addr_xcvr_dir,
    input wire logic [63:0] beat,
    input wire logic [PVS_OPT_W-1:0] strap,
    input wire logic strap64,
    output logic [PVS_ADDR_W-1:0] vme_side_address_pins_in,
    output logic [PVS_DATA_W-1:0] vme_side_data_pins_in,
    output logic vme_lword_in,
    output logic req64_pin_in
);
    // External pull-down beats the internal pull-up only when fitted
    assign req64_pin_in = !strap64;
    always_comb begin
        if (xcvr_output_enable_n) begin
            // Transceivers off: only straps and pull-downs set the pins
            vme_side_address_pins_in = strap[30:0];
            vme_side_data_pins_in = {strap[35:31], 27'h0000000};
            vme_lword_in = 1'b0;
        end else if (!data_xcvr_dir && !addr_xcvr_dir) begin
            {vme_lword_in, vme_side_address_pins_in, vme_side_data_pins_in} = beat;
        end else begin
            // Bridge owns the lines; never echo a stale word
            {vme_lword_in, vme_side_address_pins_in, vme_side_data_pins_in} = ~beat;
        end
    end
endmodule : pvs_vme_partner

// [verif/pci_vme_byte_lane_steering_test.sv]
// Self-checking bench for the lane steering block with a far-side model.
// Assumes package, design, checker and partner are compiled first.
`timescale 1ns/100ps
bind pvs_lane_steer pvs_lane_steer_props #(.SYSRST_HOLD(SYSRST_HOLD)) u_props (.sys_clk, .rst_n,
    .power_on_reset_n, .vme_sysrst_n, .acc_valid, .acc_write, .acc_unpack, .acc_be_n, .acc_addr, .pci_wdata,
    .pci_rdata, .pci_rbe_n, .acc_error, .vme_out_req, .as_out_req, .vme_side_address_pins_in,
    .vme_side_data_pins_in, .vme_lword_in, .vme_side_data_pins_out, .vme_side_pins_oe_n, .vme_ds1, .vme_ds0,
    .vme_a1, .vme_lword, .addr_xcvr_dir, .addr_strobe_xcvr_dir, .data_xcvr_dir, .syscon_group_xcvr_dir,
    .xcvr_output_enable_n);
`define CHK(nm, ex, got) begin \
    cmp_count++; \
    if ((got) !== (ex)) begin \
        miscompares++; \
        $display("BAD %s expected %h seen %h", nm, ex, got); \
    end \
end
module pci_vme_byte_lane_steering_test
    import pvs_pkg::*;
;
    typedef struct {
        logic wr, err, unp;
        logic [3:0] flags, rbe;
        logic [31:0] rd, vd, vm;
    } pvs_tb_exp_s;
    logic sys_clk, rst_n, power_on_reset_n, vme_sysrst_n, acc_valid, acc_write, acc_unpack, pend;
    logic vme_out_req, as_out_req, strap64, acc_error, vme_lword_in, req64_pin_in, pci_bus_64;
    logic [3:0] acc_be_n, pci_rbe_n;
    logic [2:0] acc_addr;
    logic [31:0] pci_wdata, pci_rdata, vme_side_data_pins_in, vme_side_data_pins_out, last_rd;
    logic [30:0] vme_side_address_pins_in;
    logic [63:0] beat;
    logic [35:0] strap, power_up_options;
    logic vme_side_pins_oe_n, vme_ds1, vme_ds0, vme_a1, vme_lword, xcvr_output_enable_n;
    logic addr_xcvr_dir, addr_modifier_xcvr_dir, addr_strobe_xcvr_dir, data_xcvr_dir;
    logic data_strobe_xcvr_dir, slave_group_xcvr_dir, syscon_group_xcvr_dir;
    wire [6:0] dirs = {addr_xcvr_dir, addr_modifier_xcvr_dir, addr_strobe_xcvr_dir, data_xcvr_dir,
        data_strobe_xcvr_dir, slave_group_xcvr_dir, syscon_group_xcvr_dir};
    int cmp_count = 0;
    int miscompares = 0;
    pvs_tb_exp_s exp_q[$];
    // Row: enables, address, ds1 ds0 a1 lword, target lane of each PCI byte
    logic [17:0] tbl [10] = '{18'h38501, 18'h35900, 18'h2e710, 18'h1fb00, 18'h30101,
        18'h25218, 18'h0e310, 18'h2081b, 18'h05418, 18'h0001b};
    //////////////////////////////////////////////////////////////
    pvs_lane_steer #(.SYSRST_HOLD(2)) DUT (.sys_clk, .rst_n, .power_on_reset_n, .vme_sysrst_n, .acc_valid,
        .acc_write, .acc_unpack, .acc_be_n, .acc_addr, .pci_wdata, .pci_rdata, .pci_rbe_n, .acc_error,
        .vme_out_req, .as_out_req, .vme_side_address_pins_in, .vme_side_data_pins_in, .vme_lword_in,
        .req64_pin_in, .vme_side_data_pins_out, .vme_side_pins_oe_n, .vme_ds1, .vme_ds0, .vme_a1, .vme_lword,
        .addr_xcvr_dir, .addr_modifier_xcvr_dir, .addr_strobe_xcvr_dir, .data_xcvr_dir, .data_strobe_xcvr_dir,
        .slave_group_xcvr_dir, .syscon_group_xcvr_dir, .xcvr_output_enable_n, .power_up_options, .pci_bus_64);
    pvs_vme_partner u_far (.xcvr_output_enable_n, .data_xcvr_dir, .addr_xcvr_dir, .beat, .strap, .strap64,
        .vme_side_address_pins_in, .vme_side_data_pins_in, .vme_lword_in, .req64_pin_in);
    //////////////////////////////////////////////////////////////
    task automatic results;
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : results
    task automatic acc(input logic wr, input logic unp, input logic a2, input logic err, input logic [17:0] t);
        pvs_tb_exp_s e;
        logic [31:0] d;
        logic [63:0] b;
        int j;
        d = $urandom;
        b = {$urandom, $urandom};
        e = '{wr: wr, err: err, unp: unp, flags: t[11:8], rbe: t[17:14], rd: 32'h0, vd: 32'h0, vm: 32'h0};
        for (int i = 0; i < 4; i++) begin
            j = t[2 * i +: 2];
            if (!t[14 + i]) begin
                e.vd[8 * j +: 8] = d[8 * i +: 8];
                e.vm[8 * j +: 8] = 8'hff;
                e.rd[8 * i +: 8] = b[8 * j +: 8];
            end
        end
        if (unp && !a2) e.rd = {b[38:32], b[63], b[46:39], b[54:47], b[62:55]};
        if (err) e.rd = last_rd;
        if (!wr) last_rd = e.rd;
        @(negedge sys_clk);
        {acc_valid, acc_write, acc_unpack, acc_be_n, acc_addr} = {1'b1, wr, unp, t[17:14], a2, t[13:12]};
        pci_wdata = d;
        beat = b;
        exp_q.push_back(e);
    endtask : acc
    //////////////////////////////////////////////////////////////
    always @(posedge sys_clk) pend <= acc_valid && rst_n;
    always @(negedge sys_clk) begin : watch
        pvs_tb_exp_s e;
        if (pend && exp_q.size() > 0) begin
            e = exp_q.pop_front();
            `CHK("acc_error", e.err, acc_error)
            if (e.err) begin
                `CHK("held_rdata", e.rd, pci_rdata)
            end else begin
                if (!e.unp) `CHK("strobes", e.flags, {vme_ds1, vme_ds0, vme_a1, vme_lword})
                if (e.wr) `CHK("vme_data", e.vd, vme_side_data_pins_out & e.vm)
                else `CHK("pci_rdata", e.rd, pci_rdata)
                if (!e.wr) `CHK("pci_rbe_n", e.rbe, pci_rbe_n)
            end
        end
    end
    initial begin
        sys_clk = 0;
        forever #5 sys_clk = ~sys_clk;
    end
    initial begin
        repeat (3000) @(posedge sys_clk);
        miscompares++;
        results();
    end
    initial begin
        {rst_n, acc_valid, acc_write, acc_unpack, vme_out_req, as_out_req, strap64} = 7'h00;
        {power_on_reset_n, vme_sysrst_n, acc_be_n, acc_addr, pci_wdata} = '1;
        {beat, strap, last_rd} = '0;
        void'($urandom(76));
        repeat (12) @(negedge sys_clk);
        rst_n = 1;
        foreach (tbl[i]) acc(1'b1, 1'b0, 1'b0, 1'b0, tbl[i]);
        foreach (tbl[i]) acc(1'b0, 1'b0, 1'b0, 1'b0, tbl[i]);
        acc(1'b0, 1'b0, 1'b0, 1'b1, 18'h39000);
        acc(1'b0, 1'b1, 1'b0, 1'b0, 18'h0001b);
        acc(1'b0, 1'b1, 1'b1, 1'b0, 18'h0001b);
        @(negedge sys_clk);
        acc_valid = 0;
        repeat (3) @(negedge sys_clk);
        $display("test lanes done");
        vme_out_req = 1;
        as_out_req = 1;
        repeat (2) @(negedge sys_clk);
        `CHK("dirs_out", 7'h7f, dirs)
        `CHK("pins_oe_n", 1'b0, vme_side_pins_oe_n)
        vme_out_req = 0;
        @(negedge sys_clk);
        `CHK("lead_oe_n", 2'h3, {vme_side_pins_oe_n, data_xcvr_dir})
        repeat (2) @(negedge sys_clk);
        `CHK("dirs_as", 7'h10, dirs)
        as_out_req = 0;
        repeat (3) @(negedge sys_clk);
        `CHK("dirs_in", 7'h00, dirs)
        $display("test direction done");
        for (int k = 0; k < 2; k++) begin
            strap = k ? 36'({$urandom, $urandom}) : 36'h000000000;
            strap64 = k ? 1'($urandom) : 1'b0;
            {power_on_reset_n, vme_sysrst_n, vme_out_req} = 3'h1;
            repeat (3) @(negedge sys_clk);
            `CHK("dirs_rst", 7'h00, dirs)
            `CHK("xcvr_oe_rst", 1'b1, xcvr_output_enable_n)
            {power_on_reset_n, vme_sysrst_n, vme_out_req} = 3'h6;
            repeat (2) @(negedge sys_clk);
            `CHK("options", strap, power_up_options)
            `CHK("bus_64", strap64, pci_bus_64)
            repeat (4) @(negedge sys_clk);
        end
        $display("test options done");
        results();
    end
endmodule : pci_vme_byte_lane_steering_test
